// ===== hdl/dpll_reference_status_regs.sv
// Reference status and observation register bank on an APB slave.
//
// Operation
// - Bits 4-3 route divider or loopback signal.
// - Bits 7-4 report references valid; rest zero.
// - Bits 5-0 show loop one source, one-hot.
// - Bits 5-0 show loop two source, one-hot.
`timescale 1ns/1ps
`default_nettype none
module dpll_reference_status_regs
	import refstat_pkg::*;
#(
	parameter int REFS = NUM_REFS
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [REFS-1:0] ref_valid_in,
	input wire logic [SRC_W-1:0] loop_one_sel,
	input wire logic [SRC_W-1:0] loop_two_sel,
	input wire logic observe_assigned,
	input wire logic m_div_in,
	input wire logic vco_one_loop_in,
	input wire logic vco_two_loop_in,
	output logic [OBS_W-1:0] observe_signal_select,
	output logic observe_out,
	output logic irq
);
	// Register state.
	logic [OBS_W-1:0] obs_sel_reg, obs_sel_next;
	logic [REFS-1:0] valid_reg, valid_next;
	logic [SRC_W-1:0] loop_one_reg, loop_one_next;
	logic [SRC_W-1:0] loop_two_reg, loop_two_next;
	logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
	logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;
	logic [RSV_COUNT-1:0][7:0] rsv_reg, rsv_next;
	logic obs_out_reg, obs_out_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic err_reg, err_next;

	logic [REFS-1:0] valid_sync;
	logic [IDX_W-1:0] idx;
	logic setup, access, wr_en, rd_setup;
	logic [7:0] wbyte;
	logic [IRQ_W-1:0] irq_event;

	sync_agree #(
		.WIDTH(REFS)
	) u_valid_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_in(ref_valid_in),
		.sync_out(valid_sync)
	);

	// Returns the reserved slot for an index, or RSV_COUNT when none.
	function automatic int rsv_slot(input logic [IDX_W-1:0] a);
		int s;
		s = RSV_COUNT;
		for (int i = 0; i < RSV_COUNT; i++) begin
			if (RSV_IDX[i] == a) begin
				s = i;
			end
		end
		return s;
	endfunction

	function automatic logic mapped(input logic [IDX_W-1:0] a);
		return (a == IDX_OBSERVE) || (a == IDX_REF_VALID) ||
			(a == IDX_LOOP_ONE) || (a == IDX_LOOP_TWO) ||
			(a == IDX_IRQ_STATUS) || (a == IDX_IRQ_MASK) ||
			(rsv_slot(a) != RSV_COUNT);
	endfunction

	assign idx = paddr[ADDR_W-1:2];
	assign setup = psel && !penable;
	assign access = psel && penable;
	// Zero wait states: every access phase completes at its first edge.
	assign pready = access;
	assign wr_en = access && pwrite && pstrb[0] && mapped(idx);
	assign rd_setup = setup && !pwrite;
	assign wbyte = pwdata[7:0];

	// Read data is latched in the setup cycle so prdata comes from a flop.
	always_comb begin
		int s;
		s = rsv_slot(idx);
		rdata_next = rdata_reg;
		err_next = err_reg;
		if (setup) begin
			rdata_next = '0;
			err_next = !mapped(idx);
			if (!pwrite) begin
				case (idx)
					IDX_OBSERVE:
						rdata_next[OBS_SEL_LSB +: OBS_W] = obs_sel_reg;
					IDX_REF_VALID:
						rdata_next[REF_VALID_LSB +: REFS] = valid_reg;
					IDX_LOOP_ONE:
						rdata_next[SRC_W-1:0] = loop_one_reg;
					IDX_LOOP_TWO:
						rdata_next[SRC_W-1:0] = loop_two_reg;
					IDX_IRQ_STATUS:
						rdata_next[IRQ_W-1:0] = irq_stat_reg;
					IDX_IRQ_MASK:
						rdata_next[IRQ_W-1:0] = irq_mask_reg;
					default: begin
						if (s != RSV_COUNT) begin
							rdata_next[7:0] = rsv_reg[s];
						end
					end
				endcase
			end
		end
	end

	// Live status: sampled every cycle, never touched by bus reads.
	always_comb begin
		valid_next = valid_sync;
		loop_one_next = loop_one_sel;
		loop_two_next = loop_two_sel;
		irq_event = '0;
		irq_event[IRQ_REF_LSB +: REFS] = valid_sync ^ valid_reg;
		irq_event[IRQ_LOOP_ONE_BIT] = loop_one_sel != loop_one_reg;
		irq_event[IRQ_LOOP_TWO_BIT] = loop_two_sel != loop_two_reg;
	end

	// Writable state; an event in the clearing cycle keeps its bit set.
	always_comb begin
		int s;
		s = rsv_slot(idx);
		obs_sel_next = obs_sel_reg;
		irq_mask_next = irq_mask_reg;
		rsv_next = rsv_reg;
		irq_stat_next = irq_stat_reg;
		if (wr_en) begin
			case (idx)
				IDX_OBSERVE:
					obs_sel_next = wbyte[OBS_SEL_LSB +: OBS_W];
				IDX_IRQ_MASK:
					irq_mask_next = wbyte[IRQ_W-1:0];
				IDX_IRQ_STATUS:
					irq_stat_next = irq_stat_reg & ~wbyte[IRQ_W-1:0];
				default: begin
					if (s != RSV_COUNT) begin
						rsv_next[s] = wbyte & RSV_WMASK[s];
					end
				end
			endcase
		end
		irq_stat_next = irq_stat_next | irq_event;
	end

	// Observation pin routing, only while the pin is given this function.
	always_comb begin
		obs_out_next = 1'b0;
		if (observe_assigned) begin
			case (obs_sel_reg)
				OBS_OFF: obs_out_next = 1'b0;
				OBS_M_DIV: obs_out_next = m_div_in;
				OBS_VCO_ONE: obs_out_next = vco_one_loop_in;
				OBS_VCO_TWO: obs_out_next = vco_two_loop_in;
				default: obs_out_next = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			obs_sel_reg <= OBS_RESET;
			valid_reg <= VALID_RESET;
			loop_one_reg <= SRC_RESET;
			loop_two_reg <= SRC_RESET;
			irq_stat_reg <= IRQ_RESET;
			irq_mask_reg <= IRQ_RESET;
			rsv_reg <= {RSV_COUNT{RSV_RESET}};
			obs_out_reg <= 1'b0;
			rdata_reg <= '0;
			err_reg <= 1'b0;
		end else begin
			obs_sel_reg <= obs_sel_next;
			valid_reg <= valid_next;
			loop_one_reg <= loop_one_next;
			loop_two_reg <= loop_two_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			rsv_reg <= rsv_next;
			obs_out_reg <= obs_out_next;
			rdata_reg <= rdata_next;
			err_reg <= err_next;
		end
	end

	assign prdata = rdata_reg;
	assign pslverr = access && err_reg;
	assign observe_signal_select = obs_sel_reg;
	assign observe_out = obs_out_reg;
	assign irq = |(irq_stat_reg & irq_mask_reg);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence obs_write_s(logic [OBS_W-1:0] code);
		access && pwrite && pstrb[0] && idx == IDX_OBSERVE &&
			pwdata[OBS_SEL_LSB +: OBS_W] == code;
	endsequence

	sequence rd_setup_s(logic [IDX_W-1:0] a);
		rd_setup && idx == a;
	endsequence

	sequence wr_s(logic [IDX_W-1:0] a);
		wr_en && idx == a;
	endsequence

	obs_write_m_a: assert property (
		obs_write_s(OBS_M_DIV) ##1 observe_assigned
		|=> observe_signal_select == OBS_M_DIV && observe_out == $past(m_div_in))
		else $error("Observe pin does not follow the divider input.");

	obs_off_a: assert property (
		!observe_assigned || obs_sel_reg == OBS_OFF |=> !observe_out)
		else $error("Observe pin drives while disabled.");

	valid_read_a: assert property (
		rd_setup_s(IDX_REF_VALID) |=> prdata[3:0] == 4'h0 &&
		prdata[REF_VALID_LSB +: REFS] == $past(valid_reg) &&
		prdata[DATA_W-1:8] == '0)
		else $error("Reference valid read returns wrong bits.");

	valid_track_a: assert property (
		$stable(ref_valid_in) [*6] |-> valid_reg == $past(ref_valid_in, 4))
		else $error("Reference valid bits do not track their inputs.");

	loop_one_read_a: assert property (
		$stable(loop_one_sel) ##1 rd_setup_s(IDX_LOOP_ONE)
		|=> prdata == {26'h0, $past(loop_one_sel, 2)})
		else $error("Loop one source read differs from live selection.");

	loop_two_read_a: assert property (
		$stable(loop_two_sel) ##1 rd_setup_s(IDX_LOOP_TWO)
		|=> prdata == {26'h0, $past(loop_two_sel, 2)})
		else $error("Loop two source read differs from live selection.");

	read_no_side_a: assert property (
		access && !pwrite && irq_event == '0
		|=> $stable(obs_sel_reg) && $stable(irq_mask_reg) &&
		$stable(irq_stat_reg) && $stable(rsv_reg))
		else $error("A read changed register state.");

	sticky_set_a: assert property (
		wr_en && idx == IDX_IRQ_STATUS && irq_event[IRQ_LOOP_ONE_BIT]
		|=> irq_stat_reg[IRQ_LOOP_ONE_BIT] &&
		(irq || !irq_mask_reg[IRQ_LOOP_ONE_BIT]))
		else $error("Event lost against a status clear.");

	// The observe pin lags its source by one clock, so each route is
	// compared with the source as it stood one edge earlier.
	obs_write_v1_a: assert property (
		obs_write_s(OBS_VCO_ONE) ##1 observe_assigned
		|=> observe_out == $past(vco_one_loop_in))
		else $error("Observe pin does not follow loopback one.");

	obs_write_v2_a: assert property (
		obs_write_s(OBS_VCO_TWO) ##1 observe_assigned
		|=> observe_out == $past(vco_two_loop_in))
		else $error("Observe pin does not follow loopback two.");

	loop_ro_a: assert property (
		wr_s(IDX_LOOP_ONE) |=> loop_one_reg == $past(loop_one_sel))
		else $error("A write disturbed the loop one status.");

	unmapped_err_a: assert property (
		setup && !mapped(idx) ##1 access |-> pslverr && prdata == '0)
		else $error("Unmapped access is not refused.");

	mapped_ok_a: assert property (
		setup && mapped(idx) ##1 access |-> !pslverr)
		else $error("Mapped access reports an error.");

	strobe_off_a: assert property (
		access && pwrite && !pstrb[0]
		|=> $stable(obs_sel_reg) && $stable(irq_mask_reg) && $stable(rsv_reg))
		else $error("A write without byte strobe changed state.");

	w1c_clear_a: assert property (
		wr_s(IDX_IRQ_STATUS) ##0
		(pwdata[IRQ_LOOP_TWO_BIT] && !irq_event[IRQ_LOOP_TWO_BIT])
		|=> !irq_stat_reg[IRQ_LOOP_TWO_BIT])
		else $error("Writing one does not clear a status bit.");

	mask_off_a: assert property (
		wr_s(IDX_IRQ_MASK) ##0 pwdata[IRQ_W-1:0] == '0 |=> !irq)
		else $error("Interrupt stays high with every source masked.");
endmodule // dpll_reference_status_regs
`default_nettype wire

// ===== hdl/refstat_pkg.sv
// Package of offsets, field layouts and reset values for the reference status bank.
package refstat_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int IDX_W = 10;
	localparam int NUM_REFS = 4;
	localparam int SRC_W = 6;
	localparam int OBS_W = 2;
	localparam int IRQ_W = 6;
	localparam int RSV_COUNT = 8;
	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_OBSERVE = 10'h2e0;
	localparam logic [IDX_W-1:0] IDX_REF_VALID = 10'h2e6;
	localparam logic [IDX_W-1:0] IDX_LOOP_ONE = 10'h2ff;
	localparam logic [IDX_W-1:0] IDX_LOOP_TWO = 10'h303;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h320;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h321;
	// Reserved registers a..h and the bits of each that hold written data.
	localparam logic [RSV_COUNT-1:0][IDX_W-1:0] RSV_IDX = {
		10'h311, 10'h310, 10'h308, 10'h307,
		10'h302, 10'h2fe, 10'h2fc, 10'h2e5};
	localparam logic [RSV_COUNT-1:0][7:0] RSV_WMASK = {
		8'h01, 8'h08, 8'h01, 8'h08, 8'hff, 8'hff, 8'h0f, 8'h1f};
	// Field positions.
	localparam int OBS_SEL_LSB = 3;
	localparam int REF_VALID_LSB = 4;
	localparam int IRQ_REF_LSB = 0;
	localparam int IRQ_LOOP_ONE_BIT = 4;
	localparam int IRQ_LOOP_TWO_BIT = 5;
	// Observation selector codes.
	localparam logic [OBS_W-1:0] OBS_OFF = 2'h0;
	localparam logic [OBS_W-1:0] OBS_M_DIV = 2'h1;
	localparam logic [OBS_W-1:0] OBS_VCO_ONE = 2'h2;
	localparam logic [OBS_W-1:0] OBS_VCO_TWO = 2'h3;
	// One-hot source codes of the loop selection fields.
	localparam logic [SRC_W-1:0] SRC_HOLDOVER = 6'h00;
	localparam logic [SRC_W-1:0] SRC_REF0 = 6'h01;
	localparam logic [SRC_W-1:0] SRC_REF1 = 6'h02;
	localparam logic [SRC_W-1:0] SRC_REF2 = 6'h04;
	localparam logic [SRC_W-1:0] SRC_REF3 = 6'h08;
	localparam logic [SRC_W-1:0] SRC_VCO_ONE = 6'h10;
	localparam logic [SRC_W-1:0] SRC_VCO_TWO = 6'h20;
	// Reset values.
	localparam logic [OBS_W-1:0] OBS_RESET = 2'h0;
	localparam logic [SRC_W-1:0] SRC_RESET = 6'h00;
	localparam logic [NUM_REFS-1:0] VALID_RESET = 4'h0;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 6'h00;
	localparam logic [7:0] RSV_RESET = 8'h00;
endpackage

// ===== hdl/sync_agree.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module sync_agree #(
	parameter int WIDTH = 4
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
	logic [WIDTH-1:0] out_next;

	// Bits where the two late stages disagree hold their last accepted value.
	always_comb begin
		out_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (out_reg & (s2_reg ^ s3_reg));
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			out_reg <= '0;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			out_reg <= out_next;
		end
	end

	assign sync_out = out_reg;
endmodule // sync_agree
`default_nettype wire

// ===== testbench/dpll_reference_status_regs_tb.sv
// Self-checking testbench for the reference status register bank.
`timescale 1ns/1ps
`default_nettype none
module dpll_reference_status_regs_tb;
	import refstat_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [3:0] pstrb = 4'hf;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic [NUM_REFS-1:0] ref_valid_in = '0;
	logic [SRC_W-1:0] loop_one_sel = '0;
	logic [SRC_W-1:0] loop_two_sel = '0;
	logic observe_assigned = 1'b0;
	logic m_div_in = 1'b0;
	logic vco_one_loop_in = 1'b0;
	logic vco_two_loop_in = 1'b0;
	logic [OBS_W-1:0] observe_signal_select;
	logic observe_out;
	logic irq;
	logic [DATA_W-1:0] rd;
	logic last_err;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [SRC_W-1:0] one_codes [6] = '{SRC_REF0, SRC_REF1, SRC_REF2,
		SRC_REF3, SRC_VCO_TWO, SRC_HOLDOVER};
	logic [SRC_W-1:0] two_codes [6] = '{SRC_REF0, SRC_REF1, SRC_REF2,
		SRC_REF3, SRC_VCO_ONE, SRC_HOLDOVER};

	dpll_reference_status_regs DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ref_valid_in(ref_valid_in), .loop_one_sel(loop_one_sel),
		.loop_two_sel(loop_two_sel), .observe_assigned(observe_assigned),
		.m_div_in(m_div_in), .vco_one_loop_in(vco_one_loop_in),
		.vco_two_loop_in(vco_two_loop_in),
		.observe_signal_select(observe_signal_select),
		.observe_out(observe_out), .irq(irq));

	initial begin
		forever #2.5 clk = ~clk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Generous ceiling; the whole sequence needs well under a thousand cycles.
	initial begin
		forever begin
			@(posedge clk);
			cyc++;
			if (cyc == 5000) begin
				error_cnt++;
				end_of_test();
			end
		end
	end

	task automatic check(input logic [DATA_W-1:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the setup edge is one clock after entry, so the
	// previous release and the next setup never land in the same step.
	task automatic apb(input logic wr, input logic [IDX_W-1:0] idx,
		input logic [7:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'h0};
		pwdata <= {24'h0, wd};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		check(rd, {24'h0, exp});
	endtask

	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		rdchk(IDX_OBSERVE, 8'h00);
		rdchk(IDX_REF_VALID, 8'h00);
		rdchk(IDX_LOOP_ONE, 8'h00);
		rdchk(IDX_LOOP_TWO, 8'h00);
		check({31'h0, last_err}, 32'h0);
		for (int i = 0; i < RSV_COUNT; i++) begin
			apb(1'b1, RSV_IDX[i], 8'hff);
			rdchk(RSV_IDX[i], RSV_WMASK[i]);
		end
		apb(1'b0, 10'h000, 8'h00);
		check({31'h0, last_err}, 32'h1);
		check(rd, 32'h0);
		$display("test reset_and_map done");
		observe_assigned <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			// For codes 1-3 only the selected source is high, so a wrong route reads low; for OFF all three are high.
			{vco_two_loop_in, vco_one_loop_in, m_div_in} <=
				(c == 0) ? 3'h7 : 3'(3'h1 << (c - 1));
			apb(1'b1, IDX_OBSERVE, 8'he7 | 8'(c << OBS_SEL_LSB));
			rdchk(IDX_OBSERVE, 8'(c << OBS_SEL_LSB));
			check({30'h0, observe_signal_select}, 32'(c));
			check({31'h0, observe_out}, {31'h0, c != 0});
		end
		// A write without the low byte strobe must leave the selector alone.
		pstrb <= 4'he;
		apb(1'b1, IDX_OBSERVE, 8'h08);
		pstrb <= 4'hf;
		rdchk(IDX_OBSERVE, 8'h18);
		observe_assigned <= 1'b0;
		repeat (3) @(posedge clk);
		check({31'h0, observe_out}, 32'h0);
		$display("test observe done");
		ref_valid_in <= 4'ha;
		repeat (8) @(posedge clk);
		apb(1'b1, IDX_REF_VALID, 8'hff);
		rdchk(IDX_REF_VALID, 8'ha0);
		rdchk(IDX_IRQ_STATUS, 8'h0a);
		check({31'h0, irq}, 32'h0);
		apb(1'b1, IDX_IRQ_MASK, 8'h3f);
		@(posedge clk);
		check({31'h0, irq}, 32'h1);
		rdchk(IDX_IRQ_STATUS, 8'h0a);
		rdchk(IDX_REF_VALID, 8'ha0);
		apb(1'b1, IDX_IRQ_STATUS, 8'h02);
		rdchk(IDX_IRQ_STATUS, 8'h08);
		apb(1'b1, IDX_IRQ_STATUS, 8'h08);
		@(posedge clk);
		check({31'h0, irq}, 32'h0);
		ref_valid_in <= 4'h5;
		repeat (8) @(posedge clk);
		rdchk(IDX_REF_VALID, 8'h50);
		apb(1'b1, IDX_IRQ_STATUS, 8'h0f);
		$display("test ref_valid_irq done");
		for (int i = 0; i < 6; i++) begin
			loop_one_sel <= one_codes[i];
			loop_two_sel <= two_codes[i];
			apb(1'b1, IDX_LOOP_ONE, 8'hff);
			rdchk(IDX_LOOP_ONE, {2'h0, one_codes[i]});
			rdchk(IDX_LOOP_TWO, {2'h0, two_codes[i]});
		end
		rdchk(IDX_IRQ_STATUS, 8'h30);
		check({31'h0, irq}, 32'h1);
		// Loop one changes in the very cycle that clears it: the set wins.
		fork
			apb(1'b1, IDX_IRQ_STATUS, 8'h30);
			begin
				repeat (2) @(posedge clk);
				loop_one_sel <= SRC_REF2;
			end
		join
		rdchk(IDX_IRQ_STATUS, 8'h10);
		rdchk(IDX_LOOP_ONE, {2'h0, SRC_REF2});
		apb(1'b1, IDX_IRQ_MASK, 8'h00);
		@(posedge clk);
		check({31'h0, irq}, 32'h0);
		$display("test loop_select done");
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rdchk(IDX_OBSERVE, 8'h00);
		rdchk(RSV_IDX[3], 8'h00);
		check({31'h0, irq}, 32'h0);
		repeat (6) @(posedge clk);
		rdchk(IDX_REF_VALID, 8'h50);
		$display("test mid_reset done");
		end_of_test();
	end
endmodule // dpll_reference_status_regs_tb
`default_nettype wire
